// File: pwr_mode_pkg.sv
package pwr_mode_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] PCTL_IDX    = 8'h87;
  localparam logic [7:0] P1WAKE_IDX  = 8'h91;
  localparam logic [7:0] SYSMODE_IDX = 8'hce;
  localparam logic [7:0] STATUS_IDX  = 8'h40;
  localparam logic [7:0] CLKCFG_IDX  = 8'h41;
  localparam logic [7:0] IRQEN_IDX   = 8'h42;

  // ==========================================================
  // Field positions
  localparam int IDLE_BIT      = 0;
  localparam int STOP_BIT      = 1;
  localparam int KEEP_SLOW_BIT = 0;
  localparam int CRYSTAL_BIT   = 0;
  localparam int ADC_SLOW_BIT  = 1;
  localparam int TMR0_SLOW_BIT = 2;
  localparam int GIE_BIT       = 7;
  localparam int P0_FLAG_BIT   = 4;
  localparam int P1_FLAG_BIT   = 5;
  localparam int IRQ_FLAG_BIT  = 6;
  localparam int ADC_SRC       = 0;
  localparam int TMR0_SRC      = 1;
  localparam int NUM_SRC       = 7;

  // ==========================================================
  // Reset values
  localparam logic [3:0] PCTL_RST    = 4'h8;
  localparam logic [7:0] P1WAKE_RST  = 8'h00;
  localparam logic [1:0] SYSMODE_RST = 2'h0;
  localparam logic [2:0] CLKCFG_RST  = 3'h0;
  localparam logic [7:0] IRQEN_RST   = 8'h00;

  // ==========================================================
  // Oscillator warm-up counts, in oscillator cycles
  localparam logic [11:0] WARM_XTAL_CYC = 12'h800;
  localparam logic [11:0] WARM_RC_CYC   = 12'h040;
  localparam logic [11:0] WARM_SLOW_CYC = 12'h004;

  // Mode codes shown in the status register
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_IDLE   = 3'h1;
  localparam logic [2:0] MODE_STOP   = 3'h2;
  localparam logic [2:0] MODE_WARM   = 3'h3;

  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_IDLE,
    ST_STOP,
    ST_WARM_FAST,
    ST_WARM_SLOW
  } pwr_state_e;

  // Clock and gate controls sent to the rest of the chip
  typedef struct packed {
    logic cpu_run;         // CPU instruction clock enable
    logic periph_run;      // Fast-clocked peripherals and interrupt logic
    logic slow_periph_run; // ADC/timer 0 kept alive on slow clock
    logic xtal_osc_en;     // External fast oscillator enable
    logic fast_rc_en;      // Internal fast RC oscillator enable
    logic slow_rc_en;      // Internal slow RC oscillator enable
  } clk_ctrl_s;

endpackage

// File: power_mode_wakeup_controller.sv
// Our own choice: register access over APB.
`timescale 1ns/10ps

// What this block does
// - Stop bit enters stop, halts CPU, oscillators
// - Leaving stop clears stop bit in hardware
// - Idle bit enters idle, only CPU halts
// - Leaving idle clears idle bit in hardware
// - Stop halts crystal, fast RC, slow RC unless keep-slow set
// - Stop keeps all registers and state intact
// - Stop disables peripherals except slow ADC/timer0
// - Slow-clocked enabled ADC/timer0 interrupt exits stop
// - Any port 0 change always wakes
// - Port 1 pin wakes only when enabled
// - Both rising and falling edges wake
// - Idle keeps system clock and peripherals running
// - Idle wakes on enabled interrupt with global enable
// - Wake event sets matching interrupt request flag
// - Crystal wake waits 2048 fast plus 4 slow
// - RC wake waits 64 fast plus 4 slow
// - Every wake returns to normal mode
// - After reset start in normal mode
// - Idle bit 0, stop bit 1, reset zero
// - Keep-slow bit chooses slow clock in stop
module power_mode_wakeup_controller
  import pwr_mode_pkg::*;
(
  input  wire logic             pclk,            // APB clock, 200 MHz
  input  wire logic             presetn,         // Async reset, active low
  input  wire logic             psel,            // APB select
  input  wire logic             penable,         // APB enable
  input  wire logic             pwrite,          // APB write
  input  wire logic [11:0]      paddr,           // APB byte address
  input  wire logic [31:0]      pwdata,          // APB write data
  output logic      [31:0]      prdata,          // APB read data
  output logic                  pready,          // APB ready
  output logic                  pslverr,         // APB error on unmapped
  input  wire logic [7:0]       port0_pin,       // Port 0 pin levels
  input  wire logic [7:0]       port1_pin,       // Port 1 pin levels
  input  wire logic             fast_osc_clk,    // Selected fast oscillator
  input  wire logic             slow_osc_clk,    // Slow oscillator
  input  wire logic [NUM_SRC-1:0] irq_req,       // Peripheral request flags
  output clk_ctrl_s             clk_ctrl,        // Clock and gate controls
  output logic                  port0_wake_irq,  // Port 0 wake request pulse
  output logic                  port1_wake_irq   // Port 1 wake request pulse
);

  // ==========================================================
  // Registers and state
  pwr_state_e       state_q;
  logic [3:0]       pctl_q;
  logic [7:0]       p1wake_q;
  logic [1:0]       sysmode_q;
  logic [2:0]       clkcfg_q;
  logic [7:0]       irqen_q;
  logic [2:0]       flags_q;
  logic [11:0]      warm_cnt_q;

  // Synchroniser stages, pins then oscillators
  logic [17:0]      sync1_q;
  logic [17:0]      sync2_q;
  logic [17:0]      sync3_q;
  logic [17:0]      stable_q;

  // Bus response and output flops
  logic [31:0]      prdata_q;
  logic             pready_q;
  logic             pslverr_q;
  clk_ctrl_s        clk_ctrl_q;
  logic             p0_irq_q;
  logic             p1_irq_q;

  // Decoded events, all combinational
  logic [17:0]      agree;
  logic [17:0]      change;
  logic             p0_wake;
  logic             p1_wake;
  logic             pin_wake;
  logic             idle_irq_wake;
  logic             stop_irq_wake;
  logic             fast_tick;
  logic             slow_tick;

  // Register access decode
  logic             wr_en;
  logic [9:0]       acc_idx;
  logic             mapped;
  logic             idle_exit;
  logic             stop_exit;
  logic [31:0]      rd_mux;

  // ==========================================================
  // Pin synchronisers
  // Three stages; only stages two and three are compared, so a
  // metastable first stage never reaches the change detector.
  // Oscillator inputs are just as asynchronous as the pins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= {slow_osc_clk, fast_osc_clk, port1_pin, port0_pin};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Stable level follows only once two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_q <= '0;
    end else begin
      stable_q <= (agree & sync3_q) | (~agree & stable_q);
    end
  end

  // Either direction of change counts as a wake edge
  assign agree     = ~(sync2_q ^ sync3_q);
  assign change    = agree & (sync3_q ^ stable_q);
  assign p0_wake   = |change[7:0];
  assign p1_wake   = |(change[15:8] & p1wake_q);
  assign pin_wake  = p0_wake | p1_wake;
  assign fast_tick = change[16] & sync3_q[16];
  assign slow_tick = change[17] & sync3_q[17];

  // ==========================================================
  // Interrupt wake sources
  // Idle needs the global enable; stop uses per-source enables.
  assign idle_irq_wake = irqen_q[GIE_BIT] & |(irq_req & irqen_q[NUM_SRC-1:0]);
  // Only slow-clocked ADC or timer 0 can run while stopped
  assign stop_irq_wake = sysmode_q[KEEP_SLOW_BIT] &
                         ((clkcfg_q[ADC_SLOW_BIT] & irq_req[ADC_SRC] & irqen_q[ADC_SRC]) |
                          (clkcfg_q[TMR0_SLOW_BIT] & irq_req[TMR0_SRC] & irqen_q[TMR0_SRC]));

  assign idle_exit = (state_q == ST_IDLE) & (pin_wake | idle_irq_wake);
  assign stop_exit = (state_q == ST_STOP) & (pin_wake | stop_irq_wake);

  // ==========================================================
  // Mode sequencer
  // Warm-up counts oscillator edges seen through the synchroniser,
  // so the fast oscillator must stay at or below a quarter of pclk.
  // Slow edges seen before the fast count ends are not counted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ST_NORMAL;
      warm_cnt_q <= '0;
    end else begin
      case (state_q)
        ST_NORMAL: begin
          warm_cnt_q <= '0;
          if (pctl_q[STOP_BIT]) begin
            state_q <= ST_STOP;
          end else if (pctl_q[IDLE_BIT]) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (idle_exit) begin
            state_q <= ST_NORMAL;
          end
        end
        ST_STOP: begin
          warm_cnt_q <= '0;
          if (stop_exit) begin
            state_q <= ST_WARM_FAST;
          end
        end
        ST_WARM_FAST: begin
          if (fast_tick) begin
            if (warm_cnt_q == (clkcfg_q[CRYSTAL_BIT] ? WARM_XTAL_CYC : WARM_RC_CYC) - 12'h001) begin
              warm_cnt_q <= '0;
              state_q    <= ST_WARM_SLOW;
            end else begin
              warm_cnt_q <= warm_cnt_q + 12'h001;
            end
          end
        end
        ST_WARM_SLOW: begin
          if (slow_tick) begin
            if (warm_cnt_q == WARM_SLOW_CYC - 12'h001) begin
              warm_cnt_q <= '0;
              state_q    <= ST_NORMAL;
            end else begin
              warm_cnt_q <= warm_cnt_q + 12'h001;
            end
          end
        end
        // Unused state codes fall back to normal mode
        default: begin
          state_q    <= ST_NORMAL;
          warm_cnt_q <= '0;
        end
      endcase
    end
  end

  // ==========================================================
  // Clock and gate controls
  // Registers keep their contents in stop; only clocks are gated.
  // Each mode sets every gate, so no stale value survives a change.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ctrl_q <= '{cpu_run: 1'b1, periph_run: 1'b1, slow_periph_run: 1'b1,
                      xtal_osc_en: 1'b0, fast_rc_en: 1'b1, slow_rc_en: 1'b1};
    end else begin
      case (state_q)
        ST_NORMAL: begin
          clk_ctrl_q.cpu_run         <= ~(pctl_q[STOP_BIT] | pctl_q[IDLE_BIT]);
          clk_ctrl_q.periph_run      <= ~pctl_q[STOP_BIT];
          clk_ctrl_q.slow_periph_run <= ~pctl_q[STOP_BIT] | sysmode_q[KEEP_SLOW_BIT];
          clk_ctrl_q.xtal_osc_en     <= clkcfg_q[CRYSTAL_BIT] & ~pctl_q[STOP_BIT];
          clk_ctrl_q.fast_rc_en      <= ~clkcfg_q[CRYSTAL_BIT] & ~pctl_q[STOP_BIT];
          clk_ctrl_q.slow_rc_en      <= ~pctl_q[STOP_BIT] | sysmode_q[KEEP_SLOW_BIT];
        end
        ST_IDLE: begin
          clk_ctrl_q.cpu_run         <= idle_exit;
          clk_ctrl_q.periph_run      <= 1'b1;
          clk_ctrl_q.slow_periph_run <= 1'b1;
          clk_ctrl_q.xtal_osc_en     <= clkcfg_q[CRYSTAL_BIT];
          clk_ctrl_q.fast_rc_en      <= ~clkcfg_q[CRYSTAL_BIT];
          clk_ctrl_q.slow_rc_en      <= 1'b1;
        end
        ST_STOP: begin
          // Fast oscillator restarts as soon as a wake is seen
          clk_ctrl_q.cpu_run         <= 1'b0;
          clk_ctrl_q.periph_run      <= 1'b0;
          clk_ctrl_q.slow_periph_run <= sysmode_q[KEEP_SLOW_BIT];
          clk_ctrl_q.xtal_osc_en     <= clkcfg_q[CRYSTAL_BIT] & stop_exit;
          clk_ctrl_q.fast_rc_en      <= ~clkcfg_q[CRYSTAL_BIT] & stop_exit;
          clk_ctrl_q.slow_rc_en      <= sysmode_q[KEEP_SLOW_BIT] | stop_exit;
        end
        ST_WARM_FAST, ST_WARM_SLOW: begin
          clk_ctrl_q.cpu_run         <= (state_q == ST_WARM_SLOW) & slow_tick &
                                        (warm_cnt_q == WARM_SLOW_CYC - 12'h001);
          clk_ctrl_q.periph_run      <= (state_q == ST_WARM_SLOW) & slow_tick &
                                        (warm_cnt_q == WARM_SLOW_CYC - 12'h001);
          clk_ctrl_q.slow_periph_run <= 1'b1;
          clk_ctrl_q.xtal_osc_en     <= clkcfg_q[CRYSTAL_BIT];
          clk_ctrl_q.fast_rc_en      <= ~clkcfg_q[CRYSTAL_BIT];
          clk_ctrl_q.slow_rc_en      <= 1'b1;
        end
        default: begin
          clk_ctrl_q <= '{cpu_run: 1'b1, periph_run: 1'b1, slow_periph_run: 1'b1,
                          xtal_osc_en: 1'b0, fast_rc_en: 1'b1, slow_rc_en: 1'b1};
        end
      endcase
    end
  end

  // ==========================================================
  // Wake request pulses to the interrupt flags
  // One cycle only; the status flags keep the cause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p0_irq_q <= 1'b0;
      p1_irq_q <= 1'b0;
    end else begin
      p0_irq_q <= (idle_exit | stop_exit) & p0_wake;
      p1_irq_q <= (idle_exit | stop_exit) & p1_wake;
    end
  end

  // ==========================================================
  // APB decode
  assign acc_idx = paddr[11:2];
  assign wr_en   = psel & penable & pready_q & pwrite & mapped;
  assign mapped  = (acc_idx == {2'b00, PCTL_IDX}) | (acc_idx == {2'b00, P1WAKE_IDX}) |
                   (acc_idx == {2'b00, SYSMODE_IDX}) | (acc_idx == {2'b00, STATUS_IDX}) |
                   (acc_idx == {2'b00, CLKCFG_IDX}) | (acc_idx == {2'b00, IRQEN_IDX});

  // Read mux; unused bits read as zero
  always_comb begin
    rd_mux = '0;
    if (acc_idx == {2'b00, PCTL_IDX}) begin
      rd_mux[3:0] = pctl_q;
    end else if (acc_idx == {2'b00, P1WAKE_IDX}) begin
      rd_mux[7:0] = p1wake_q;
    end else if (acc_idx == {2'b00, SYSMODE_IDX}) begin
      rd_mux[1:0] = sysmode_q;
    end else if (acc_idx == {2'b00, STATUS_IDX}) begin
      rd_mux[6:4] = flags_q;
      case (state_q)
        ST_NORMAL: rd_mux[2:0] = MODE_NORMAL;
        ST_IDLE:   rd_mux[2:0] = MODE_IDLE;
        ST_STOP:   rd_mux[2:0] = MODE_STOP;
        default:   rd_mux[2:0] = MODE_WARM;
      endcase
    end else if (acc_idx == {2'b00, CLKCFG_IDX}) begin
      rd_mux[2:0] = clkcfg_q;
    end else if (acc_idx == {2'b00, IRQEN_IDX}) begin
      rd_mux[7:0] = irqen_q;
    end
  end

  // One wait-free access cycle; data captured in setup
  // The error bit rides with ready so both are seen together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~mapped;
      prdata_q  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Power control: hardware clear on wake beats a software write
  // A write landing in the wake cycle is lost; software rereads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pctl_q <= PCTL_RST;
    end else if (idle_exit) begin
      pctl_q[IDLE_BIT] <= 1'b0;
    end else if (stop_exit) begin
      pctl_q[STOP_BIT] <= 1'b0;
      pctl_q[IDLE_BIT] <= 1'b0;
    end else if (wr_en & (acc_idx == {2'b00, PCTL_IDX})) begin
      pctl_q <= pwdata[3:0];
    end
  end

  // Plain configuration registers; contents survive every mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p1wake_q  <= P1WAKE_RST;
      sysmode_q <= SYSMODE_RST;
      clkcfg_q  <= CLKCFG_RST;
      irqen_q   <= IRQEN_RST;
    end else if (wr_en) begin
      if (acc_idx == {2'b00, P1WAKE_IDX}) begin
        p1wake_q <= pwdata[7:0];
      end
      // Takes effect before a later stop write, as software must order it
      if (acc_idx == {2'b00, SYSMODE_IDX}) begin
        sysmode_q <= pwdata[1:0];
      end
      if (acc_idx == {2'b00, CLKCFG_IDX}) begin
        clkcfg_q <= pwdata[2:0];
      end
      if (acc_idx == {2'b00, IRQEN_IDX}) begin
        irqen_q <= pwdata[7:0];
      end
    end
  end

  // Sticky wake cause flags, write one to clear; a new cause wins
  // A zero in the written word leaves that flag alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= '0;
    end else begin
      flags_q <= ({stop_exit & stop_irq_wake | idle_exit & idle_irq_wake,
                   (idle_exit | stop_exit) & p1_wake,
                   (idle_exit | stop_exit) & p0_wake}) |
                 (flags_q & ~((wr_en & (acc_idx == {2'b00, STATUS_IDX})) ?
                              pwdata[IRQ_FLAG_BIT:P0_FLAG_BIT] : 3'h0));
    end
  end

  // Every output is driven straight from a flop
  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign clk_ctrl       = clk_ctrl_q;
  assign port0_wake_irq = p0_irq_q;
  assign port1_wake_irq = p1_irq_q;

endmodule

// File: pmw_checker.sv
`timescale 1ns/10ps
// ==========================================
// Port-level checks of the power mode controller
module pmw_checker
  import pwr_mode_pkg::*;
(
  input wire logic               pclk,           // Clock
  input wire logic               presetn,        // Reset, active low
  input wire logic               psel,           // APB select
  input wire logic               penable,        // APB enable
  input wire logic               pwrite,         // APB write
  input wire logic [11:0]        paddr,          // APB address
  input wire logic [31:0]        pwdata,         // APB write data
  input wire logic [31:0]        prdata,         // APB read data
  input wire logic               pready,         // APB ready
  input wire logic               pslverr,        // APB error
  input wire logic [7:0]         port0_pin,      // Port 0 levels
  input wire logic [7:0]         port1_pin,      // Port 1 levels
  input wire logic               fast_osc_clk,   // Fast oscillator
  input wire logic               slow_osc_clk,   // Slow oscillator
  input wire logic [NUM_SRC-1:0] irq_req,        // Requests
  input wire clk_ctrl_s          clk_ctrl,       // Clock controls
  input wire logic               port0_wake_irq, // Port 0 wake pulse
  input wire logic               port1_wake_irq  // Port 1 wake pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Committed write to power control, and warm-up state
  wire logic        pc_wr = psel && penable && pready && pwrite && paddr == {2'b00, PCTL_IDX, 2'b00};
  wire logic        warm  = (clk_ctrl.xtal_osc_en || clk_ctrl.fast_rc_en) && !clk_ctrl.periph_run;
  wire logic [11:0] need  = clk_ctrl.xtal_osc_en ? WARM_XTAL_CYC : WARM_RC_CYC;
  logic             fast_q;
  logic             slow_q;
  logic [11:0]      fcnt_q;
  logic [11:0]      scnt_q;
  // Raw edge counts run ahead of the design's synchronised ones, so they are a safe upper bound
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_q <= 1'b0;
      slow_q <= 1'b0;
      fcnt_q <= '0;
      scnt_q <= '0;
    end else begin
      fast_q <= fast_osc_clk;
      slow_q <= slow_osc_clk;
      fcnt_q <= !warm ? '0 : fcnt_q + 12'(fast_osc_clk && !fast_q);
      scnt_q <= !warm ? '0 : scnt_q + 12'(slow_osc_clk && !slow_q && fcnt_q >= need);
    end
  end
  a_reset_normal: assert property ($rose(presetn) |-> clk_ctrl.cpu_run && clk_ctrl.periph_run)
    else $error("not in normal mode after reset");
  a_stop_entry: assert property (pc_wr && pwdata[STOP_BIT] |-> ##[1:3] !clk_ctrl.cpu_run
    && !clk_ctrl.xtal_osc_en && !clk_ctrl.fast_rc_en) else $error("stop request not obeyed");
  a_idle_osc: assert property (!clk_ctrl.cpu_run && clk_ctrl.periph_run |->
    clk_ctrl.fast_rc_en || clk_ctrl.xtal_osc_en) else $error("fast clock off in idle");
  a_stop_gated: assert property (!(clk_ctrl.xtal_osc_en || clk_ctrl.fast_rc_en) |->
    !clk_ctrl.cpu_run && !clk_ctrl.periph_run) else $error("logic running without fast clock");
  a_slow_gate: assert property (!clk_ctrl.slow_rc_en |-> !clk_ctrl.slow_periph_run)
    else $error("slow peripherals run without slow clock");
  a_pulse_one: assert property (port0_wake_irq || port1_wake_irq |=>
    !port0_wake_irq && !port1_wake_irq) else $error("wake pulse longer than one cycle");
  a_port0_wake: assert property (!clk_ctrl.cpu_run && clk_ctrl.periph_run &&
    port0_pin != $past(port0_pin) |-> ##[2:8] clk_ctrl.cpu_run) else $error("port 0 change did not wake");
  a_warm_count: assert property ($rose(clk_ctrl.cpu_run) && $past(warm) |->
    fcnt_q >= need && scnt_q >= 12'(WARM_SLOW_CYC)) else $error("warm-up ended early");
  c_stop_wake: cover property ($rose(clk_ctrl.cpu_run) && $past(warm));
  c_p1_wake: cover property (port1_wake_irq);
  c_idle: cover property (!clk_ctrl.cpu_run && clk_ctrl.periph_run);
endmodule

bind power_mode_wakeup_controller pmw_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port0_pin(port0_pin),
  .port1_pin(port1_pin), .fast_osc_clk(fast_osc_clk), .slow_osc_clk(slow_osc_clk), .irq_req(irq_req),
  .clk_ctrl(clk_ctrl), .port0_wake_irq(port0_wake_irq), .port1_wake_irq(port1_wake_irq));

// File: osc_model.sv
`timescale 1ns/10ps
// ==========================================
// Oscillators: run only while enabled, sit low otherwise
module osc_model (
  input  wire logic fast_en,  // Fast oscillator enable
  input  wire logic slow_en,  // Slow oscillator enable
  output logic      fast_clk, // 50 MHz while running
  output logic      slow_clk  // 25 MHz while running
);
  // Fast oscillator, a quarter of pclk so the sampler sees each phase twice
  initial fast_clk = 1'b0;
  always #10 fast_clk = fast_en & ~fast_clk;
  // Slow oscillator, far faster than a real one to keep warm-up short
  initial slow_clk = 1'b0;
  always #20 slow_clk = slow_en & ~slow_clk;
endmodule

// File: power_mode_wakeup_controller_test.sv
`timescale 1ns/10ps
// ==========================================
// Bench for the power mode and wake-up controller
module power_mode_wakeup_controller_test;
  import pwr_mode_pkg::*;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata;
  logic               fast_osc_clk, slow_osc_clk, port0_wake_irq, port1_wake_irq;
  logic [7:0]         port0_pin, port1_pin;
  logic [NUM_SRC-1:0] irq_req;
  clk_ctrl_s          clk_ctrl;
  int                 num_errors, check_count, cyc, p0_seen, p1_seen;
  power_mode_wakeup_controller u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port0_pin(port0_pin),
    .port1_pin(port1_pin), .fast_osc_clk(fast_osc_clk), .slow_osc_clk(slow_osc_clk), .irq_req(irq_req),
    .clk_ctrl(clk_ctrl), .port0_wake_irq(port0_wake_irq), .port1_wake_irq(port1_wake_irq));
  osc_model u_osc (.fast_en(clk_ctrl.xtal_osc_en | clk_ctrl.fast_rc_en), .slow_en(clk_ctrl.slow_rc_en),
    .fast_clk(fast_osc_clk), .slow_clk(slow_osc_clk));
  // 200 MHz clock
  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;
  // Wake pulse tally and cycle ceiling; the longest wake-up is near 8300 cycles
  always @(posedge pclk) begin
    cyc++;
    if (port0_wake_irq === 1'b1) p0_seen++;
    if (port1_wake_irq === 1'b1) p1_seen++;
    if (cyc == 40000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ok(input logic c);
    chk({31'h0, c}, 32'h1);
  endtask
  // One APB transfer; an idle cycle follows so the next setup never lands in the same step
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 32'h0, r, e);
    chk(r, exp);
  endtask
  task automatic wait_run(output int n);
    n = 0;
    while (clk_ctrl.cpu_run !== 1'b1 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  // Reset values, write-back and an unmapped address
  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    chk({26'h0, clk_ctrl}, 32'h3b);
    rd(PCTL_IDX, 32'h8);
    rd(SYSMODE_IDX, 32'h0);
    rd(STATUS_IDX, 32'h0);
    rd(P1WAKE_IDX, 32'h0);
    wr(P1WAKE_IDX, 32'h1a5);
    rd(P1WAKE_IDX, 32'ha5);
    apb(1'b0, 8'h50, 32'h0, r, e);
    ok(e === 1'b1 && r === 32'h0);
    $display("test regs done");
  endtask
  // Idle, woken by a rising then a falling port 0 edge
  task automatic t_idle_p0;
    int n;
    for (int i = 0; i < 2; i++) begin
      wr(PCTL_IDX, 32'h9);
      repeat (3) @(posedge pclk);
      chk({26'h0, clk_ctrl}, 32'h1b);
      port0_pin <= port0_pin ^ 8'h80;
      wait_run(n);
      ok(n < 10);
      rd(PCTL_IDX, 32'h8);
      rd(STATUS_IDX, 32'h10);
      wr(STATUS_IDX, 32'h70);
    end
    chk(p0_seen, 32'h2);
    $display("test idle port0 done");
  endtask
  // Port 1 wakes only through an enabled pin
  task automatic t_idle_p1;
    int n;
    wr(P1WAKE_IDX, 32'h01);
    wr(PCTL_IDX, 32'h9);
    port1_pin <= 8'h08;
    repeat (20) @(posedge pclk);
    ok(clk_ctrl.cpu_run === 1'b0);
    port1_pin <= 8'h09;
    wait_run(n);
    ok(n < 10);
    rd(STATUS_IDX, 32'h20);
    wr(STATUS_IDX, 32'h70);
    chk(p1_seen, 32'h1);
    $display("test idle port1 done");
  endtask
  // An interrupt wakes idle only once the global enable is set too
  task automatic t_idle_irq;
    int n;
    wr(IRQEN_IDX, 32'h04);
    irq_req <= 7'h04;
    wr(PCTL_IDX, 32'h9);
    repeat (20) @(posedge pclk);
    ok(clk_ctrl.cpu_run === 1'b0);
    rd(STATUS_IDX, 32'h1);
    wr(IRQEN_IDX, 32'h84);
    wait_run(n);
    ok(n < 10);
    irq_req <= 7'h00;
    rd(STATUS_IDX, 32'h40);
    wr(STATUS_IDX, 32'h70);
    $display("test idle irq done");
  endtask
  // Stop without keep-slow ignores the slow interrupt; port 0 wakes after the warm-up
  task automatic t_stop_pin;
    int n, need;
    for (int k = 0; k < 2; k++) begin
      wr(CLKCFG_IDX, 32'h2 + 32'(k));
      wr(IRQEN_IDX, 32'h81);
      wr(PCTL_IDX, 32'ha + 32'(k));
      irq_req <= 7'h01;
      repeat (20) @(posedge pclk);
      chk({26'h0, clk_ctrl}, 32'h0);
      irq_req <= 7'h00;
      need = (k == 1 ? 2048 : 64) * 4 + 4 * 8;
      port0_pin <= port0_pin ^ 8'h02;
      wait_run(n);
      ok(n >= need && n <= need + 60);
      chk({26'h0, clk_ctrl}, k == 1 ? 32'h3d : 32'h3b);
      rd(PCTL_IDX, 32'h8);
      rd(STATUS_IDX, 32'h10);
      wr(STATUS_IDX, 32'h70);
    end
    $display("test stop pin done");
  endtask
  // Keep-slow set ahead of stop; the slow-clocked ADC request, then the timer 0 request, ends stop
  task automatic t_stop_irq;
    int n;
    wr(SYSMODE_IDX, 32'h1);
    for (int k = 0; k < 2; k++) begin
      wr(CLKCFG_IDX, 32'h2 << k);
      wr(IRQEN_IDX, 32'h1 << k);
      wr(PCTL_IDX, 32'ha);
      repeat (5) @(posedge pclk);
      chk({26'h0, clk_ctrl}, 32'h09);
      rd(STATUS_IDX, 32'h2);
      irq_req <= 7'h01 << k;
      wait_run(n);
      ok(n <= 64 * 4 + 100);
      irq_req <= 7'h00;
      rd(PCTL_IDX, 32'h8);
      rd(STATUS_IDX, 32'h40);
      wr(STATUS_IDX, 32'h70);
    end
    rd(SYSMODE_IDX, 32'h1);
    rd(P1WAKE_IDX, 32'h1);
    $display("test stop irq done");
  endtask
  // Main sequence
  initial begin
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    port0_pin = 8'h00;
    port1_pin = 8'h00;
    irq_req   = 7'h00;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_idle_p0();
    t_idle_p1();
    t_idle_irq();
    t_stop_pin();
    t_stop_irq();
    summarize();
  end
endmodule
